// >>> hw/mfpa_top.sv
`timescale 1ns/100ps
module mfpa_top (
  // system
  input  wire logic                                 mclk,
  input  wire logic                                 reset_n,
  // avalon-mm slave
  input  wire logic [mfpa_pkg::ADDR_W-1:0]          avs_address,
  input  wire logic                                 avs_read,
  input  wire logic                                 avs_write,
  input  wire logic [mfpa_pkg::DATA_W-1:0]          avs_writedata,
  output logic      [mfpa_pkg::DATA_W-1:0]          avs_readdata,
  output logic                                      avs_waitrequest,
  // generated fifo clocks
  output logic                                      in_fifo_clk,
  output logic                                      out_fifo_clk,
  // buffered copies back on global clock inputs
  input  wire logic                                 in_global_clock_input,
  input  wire logic                                 out_global_clock_input,
  // input fifo pins
  input  wire logic [mfpa_pkg::DATA_W-1:0]          in_fifo_data,
  input  wire logic [mfpa_pkg::NUM_FIFOS-1:0]       in_fifo_empty,
  input  wire logic [mfpa_pkg::NUM_FIFOS-1:0]       in_fifo_aempty,
  output logic      [mfpa_pkg::NUM_FIFOS-1:0]       in_fifo_ren,
  output logic      [mfpa_pkg::NUM_FIFOS-1:0]       in_fifo_oe,
  // output fifo pins
  output logic      [mfpa_pkg::DATA_W-1:0]          out_fifo_data,
  output logic      [mfpa_pkg::NUM_FIFOS-1:0]       out_fifo_wen,
  input  wire logic [mfpa_pkg::NUM_FIFOS-1:0]       out_fifo_full,
  input  wire logic [mfpa_pkg::NUM_FIFOS-1:0]       out_fifo_afull,
  // user receive stream, on in_global_clock_input
  output logic      [mfpa_pkg::DATA_W-1:0]          rx_data,
  output logic                                      rx_valid,
  // user transmit stream, on out_global_clock_input
  input  wire logic [mfpa_pkg::DATA_W-1:0]          tx_data,
  input  wire logic                                 tx_valid,
  output logic                                      tx_ready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0]                          div_cnt;
  logic [5:0]                          rst_cnt;
  logic                                link_rst_req_n;
  logic                                in_rst_n;
  logic                                out_rst_n;
  logic                                bus_ack;
  logic                                in_ctrl_en;
  logic [mfpa_pkg::SEL_W-1:0]          in_ctrl_sel;
  logic                                out_ctrl_en;
  logic                                out_ctrl_mcast;
  logic [mfpa_pkg::NUM_FIFOS-1:0]      out_ctrl_mask;
  logic [mfpa_pkg::IN_CFG_W-1:0]       in_cfg;
  logic [mfpa_pkg::OUT_CFG_W-1:0]      out_cfg;
  logic [mfpa_pkg::STAT_W-1:0]         in_stat_m;
  logic [mfpa_pkg::STAT_W-1:0]         out_stat_m;
  logic [mfpa_pkg::STAT_W-1:0]         in_stat_l;
  logic [mfpa_pkg::STAT_W-1:0]         out_stat_l;
  logic [mfpa_pkg::NUM_FIFOS-1:0]      in_onehot;
  logic                                in_active;
  logic                                in_empty_sel;
  logic                                in_aempty_sel;
  logic                                next_ren;
  logic                                ren_d;
  logic [mfpa_pkg::CNT_W-1:0]          rd_count;
  logic [mfpa_pkg::NUM_FIFOS-1:0]      out_mask;
  logic                                out_active;
  logic                                out_full_sel;
  logic                                out_afull_sel;
  logic [mfpa_pkg::CNT_W-1:0]          wr_count;

  // ----------------------------------------------------------------
  // fifo clock generation
  // ----------------------------------------------------------------
  // one divider feeds both clocks; each direction has its own output flop
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      div_cnt      <= '0;
      in_fifo_clk  <= 1'b0;
      out_fifo_clk <= 1'b0;
    end else if (div_cnt == 6'(mfpa_pkg::FIFO_CLK_HALF_CYC - 1)) begin
      div_cnt      <= '0;
      in_fifo_clk  <= ~in_fifo_clk;
      out_fifo_clk <= ~out_fifo_clk;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // link resets
  // ----------------------------------------------------------------
  // the link clocks stop in reset, so the link reset is held on past
  // the release long enough for several link edges to see it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rst_cnt        <= '0;
      link_rst_req_n <= 1'b0;
    end else if (rst_cnt != 6'(mfpa_pkg::LINK_RST_HOLD_CYC)) begin
      rst_cnt        <= rst_cnt + 6'h01;
      link_rst_req_n <= 1'b0;
    end else begin
      link_rst_req_n <= 1'b1;
    end
  end

  mfpa_sync #(.WIDTH(1)) u_in_rst (
    .clk (in_global_clock_input),
    .d   (link_rst_req_n),
    .q   (in_rst_n)
  );

  mfpa_sync #(.WIDTH(1)) u_out_rst (
    .clk (out_global_clock_input),
    .d   (link_rst_req_n),
    .q   (out_rst_n)
  );

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  // one wait state: the answer comes at the second edge of a request
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end
  end

  // control registers, written at the edge that ends the wait
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      in_ctrl_en     <= 1'b0;
      in_ctrl_sel    <= mfpa_pkg::SEL_RST;
      out_ctrl_en    <= 1'b0;
      out_ctrl_mcast <= 1'b0;
      out_ctrl_mask  <= mfpa_pkg::MASK_RST;
    end else if (avs_write && bus_ack) begin
      if (avs_address == mfpa_pkg::REG_IN_CTRL) begin
        in_ctrl_en  <= avs_writedata[mfpa_pkg::CTRL_EN_BIT];
        in_ctrl_sel <= avs_writedata[mfpa_pkg::CTRL_SEL_LSB +: mfpa_pkg::SEL_W];
      end
      if (avs_address == mfpa_pkg::REG_OUT_CTRL) begin
        out_ctrl_en    <= avs_writedata[mfpa_pkg::CTRL_EN_BIT];
        out_ctrl_mcast <= avs_writedata[mfpa_pkg::CTRL_MCAST_BIT];
        out_ctrl_mask  <= avs_writedata[mfpa_pkg::CTRL_MASK_LSB +: mfpa_pkg::NUM_FIFOS];
      end
    end
  end

  // read data registered when the request is first seen
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      avs_readdata <= mfpa_pkg::RD_ZERO;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= mfpa_pkg::RD_ZERO;
      case (avs_address)
        mfpa_pkg::REG_IN_CTRL: begin
          avs_readdata[mfpa_pkg::CTRL_EN_BIT]                    <= in_ctrl_en;
          avs_readdata[mfpa_pkg::CTRL_SEL_LSB +: mfpa_pkg::SEL_W] <= in_ctrl_sel;
        end
        mfpa_pkg::REG_OUT_CTRL: begin
          avs_readdata[mfpa_pkg::CTRL_EN_BIT]                         <= out_ctrl_en;
          avs_readdata[mfpa_pkg::CTRL_MCAST_BIT]                      <= out_ctrl_mcast;
          avs_readdata[mfpa_pkg::CTRL_MASK_LSB +: mfpa_pkg::NUM_FIFOS] <= out_ctrl_mask;
        end
        mfpa_pkg::REG_IN_STAT: begin
          avs_readdata[mfpa_pkg::STAT_W-1:0] <= in_stat_m;
        end
        mfpa_pkg::REG_OUT_STAT: begin
          avs_readdata[mfpa_pkg::STAT_W-1:0] <= out_stat_m;
        end
        default: begin
          avs_readdata <= mfpa_pkg::RD_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // crossings between the bus domain and the two link domains
  // ----------------------------------------------------------------
  // config and status are whole words, so each rides a handshake
  mfpa_hshk #(.WIDTH(mfpa_pkg::IN_CFG_W)) u_in_cfg (
    .src_clk   (mclk),
    .src_rst_n (reset_n),
    .src_data  ({in_ctrl_sel, in_ctrl_en}),
    .dst_clk   (in_global_clock_input),
    .dst_rst_n (in_rst_n),
    .dst_data  (in_cfg)
  );

  mfpa_hshk #(.WIDTH(mfpa_pkg::OUT_CFG_W)) u_out_cfg (
    .src_clk   (mclk),
    .src_rst_n (reset_n),
    .src_data  ({out_ctrl_mask, out_ctrl_mcast, out_ctrl_en}),
    .dst_clk   (out_global_clock_input),
    .dst_rst_n (out_rst_n),
    .dst_data  (out_cfg)
  );

  mfpa_hshk #(.WIDTH(mfpa_pkg::STAT_W)) u_in_stat (
    .src_clk   (in_global_clock_input),
    .src_rst_n (in_rst_n),
    .src_data  (in_stat_l),
    .dst_clk   (mclk),
    .dst_rst_n (reset_n),
    .dst_data  (in_stat_m)
  );

  mfpa_hshk #(.WIDTH(mfpa_pkg::STAT_W)) u_out_stat (
    .src_clk   (out_global_clock_input),
    .src_rst_n (out_rst_n),
    .src_data  (out_stat_l),
    .dst_clk   (mclk),
    .dst_rst_n (reset_n),
    .dst_data  (out_stat_m)
  );

  // ----------------------------------------------------------------
  // input side, on the returned input clock
  // ----------------------------------------------------------------
  // flags come from fifos on this same clock, so they need no sync
  assign in_onehot     = mfpa_pkg::sel_onehot(in_cfg[mfpa_pkg::IN_CFG_W-1:1]);
  assign in_active     = in_cfg[0] & (|in_onehot);
  assign in_empty_sel  = |(in_fifo_empty & in_onehot);
  assign in_aempty_sel = |(in_fifo_aempty & in_onehot);
  // burst while plenty remains, else one read then a look at empty
  assign next_ren      = in_active & ~in_empty_sel & (~in_aempty_sel | ~(|in_fifo_ren));
  assign in_stat_l     = {in_active, in_aempty_sel, in_empty_sel, rd_count};

  // output enable stays on the one selected fifo while reading is on
  always_ff @(posedge in_global_clock_input) begin
    if (!in_rst_n) begin
      in_fifo_oe <= '0;
    end else begin
      in_fifo_oe <= in_active ? in_onehot : '0;
    end
  end

  // read enable toward the one selected fifo
  always_ff @(posedge in_global_clock_input) begin
    if (!in_rst_n) begin
      in_fifo_ren <= '0;
    end else begin
      in_fifo_ren <= next_ren ? in_onehot : '0;
    end
  end

  // word appears the cycle after the read edge and is caught then
  always_ff @(posedge in_global_clock_input) begin
    if (!in_rst_n) begin
      ren_d    <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= '0;
    end else begin
      ren_d    <= |in_fifo_ren;
      rx_valid <= ren_d;
      if (ren_d) begin
        rx_data <= in_fifo_data;
      end
    end
  end

  // words read, wraps
  always_ff @(posedge in_global_clock_input) begin
    if (!in_rst_n) begin
      rd_count <= '0;
    end else if (rx_valid) begin
      rd_count <= rd_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // output side, on the returned output clock
  // ----------------------------------------------------------------
  // without multicast only the lowest masked fifo is written
  assign out_mask      = out_cfg[1] ? out_cfg[mfpa_pkg::OUT_CFG_W-1:2]
                                    : mfpa_pkg::lowest_bit(out_cfg[mfpa_pkg::OUT_CFG_W-1:2]);
  assign out_active    = out_cfg[0] & (|out_mask);
  assign out_full_sel  = |(out_fifo_full & out_mask);
  assign out_afull_sel = |(out_fifo_afull & out_mask);
  assign tx_ready      = out_active & ~out_full_sel & (~out_afull_sel | ~(|out_fifo_wen));
  assign out_stat_l    = {out_active, out_afull_sel, out_full_sel, wr_count};

  // write enable and data, one word per clock at most
  always_ff @(posedge out_global_clock_input) begin
    if (!out_rst_n) begin
      out_fifo_wen  <= '0;
      out_fifo_data <= '0;
    end else begin
      out_fifo_wen <= (tx_valid && tx_ready) ? out_mask : '0;
      if (tx_valid && tx_ready) begin
        out_fifo_data <= tx_data;
      end
    end
  end

  // words written, wraps
  always_ff @(posedge out_global_clock_input) begin
    if (!out_rst_n) begin
      wr_count <= '0;
    end else if (|out_fifo_wen) begin
      wr_count <= wr_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_read_issued;
    |in_fifo_ren;
  endsequence

  sequence s_word_caught;
    !rx_valid ##1 rx_valid;
  endsequence

  property p_in_oe_single;
    @(posedge in_global_clock_input) disable iff (!link_rst_req_n || !in_rst_n)
    $onehot0(in_fifo_oe);
  endproperty
  a_in_oe_single: assert property (p_in_oe_single) else $error("two input output enables");

  property p_in_ren_single;
    @(posedge in_global_clock_input) disable iff (!link_rst_req_n || !in_rst_n)
    $onehot0(in_fifo_ren) && ((in_fifo_ren & ~in_fifo_oe) == '0);
  endproperty
  a_in_ren_single: assert property (p_in_ren_single) else $error("bad input read enable");

  property p_ren_not_empty;
    @(posedge in_global_clock_input) disable iff (!link_rst_req_n || !in_rst_n)
    s_read_issued |-> $past(in_active && !in_empty_sel);
  endproperty
  a_ren_not_empty: assert property (p_ren_not_empty) else $error("read from empty fifo");

  property p_ren_single_low;
    @(posedge in_global_clock_input) disable iff (!link_rst_req_n || !in_rst_n)
    (s_read_issued and in_aempty_sel) |=> !(|in_fifo_ren);
  endproperty
  a_ren_single_low: assert property (p_ren_single_low) else $error("burst while almost empty");

  property p_rx_follows;
    @(posedge in_global_clock_input) disable iff (!link_rst_req_n || !in_rst_n)
    (s_read_issued and !ren_d) |=> s_word_caught;
  endproperty
  a_rx_follows: assert property (p_rx_follows) else $error("word not caught two cycles on");

  property p_wen_data;
    @(posedge out_global_clock_input) disable iff (!link_rst_req_n || !out_rst_n)
    (tx_valid && tx_ready) |=> (|out_fifo_wen) && (out_fifo_data == $past(tx_data));
  endproperty
  a_wen_data: assert property (p_wen_data) else $error("write lost");

  property p_wen_single_low;
    @(posedge out_global_clock_input) disable iff (!link_rst_req_n || !out_rst_n)
    ((|out_fifo_wen) && out_afull_sel) |=> !(|out_fifo_wen);
  endproperty
  a_wen_single_low: assert property (p_wen_single_low) else $error("burst while almost full");

  property p_wen_single;
    @(posedge out_global_clock_input) disable iff (!link_rst_req_n || !out_rst_n)
    !out_cfg[1] |-> $onehot0(out_fifo_wen);
  endproperty
  a_wen_single: assert property (p_wen_single) else $error("several fifos written");

  property p_clk_rate;
    @(posedge mclk) disable iff (!reset_n)
    $changed(in_fifo_clk) |=> $stable(in_fifo_clk) ##1 $changed(in_fifo_clk);
  endproperty
  a_clk_rate: assert property (p_clk_rate) else $error("fifo clock rate wrong");

endmodule

// >>> shared/mfpa_pkg.sv
package mfpa_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_FIFOS = 6;
  localparam int DATA_W    = 32;
  localparam int SEL_W     = 3;
  localparam int CNT_W     = 16;
  localparam int ADDR_W    = 5;

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_IN_CTRL  = 5'h00;
  localparam logic [ADDR_W-1:0] REG_OUT_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] REG_IN_STAT  = 5'h08;
  localparam logic [ADDR_W-1:0] REG_OUT_STAT = 5'h0C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_MCAST_BIT  = 1;
  localparam int CTRL_SEL_LSB    = 4;
  localparam int CTRL_MASK_LSB   = 8;
  localparam int STAT_CNT_LSB    = 0;
  localparam int STAT_FLAG_BIT   = 16;
  localparam int STAT_AFLAG_BIT  = 17;
  localparam int STAT_ACTIVE_BIT = 18;
  localparam int STAT_W          = 19;
  localparam int IN_CFG_W        = 1 + SEL_W;
  localparam int OUT_CFG_W       = 2 + NUM_FIFOS;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0]     SEL_RST  = 3'h0;
  localparam logic [NUM_FIFOS-1:0] MASK_RST = 6'h01;
  localparam logic [DATA_W-1:0]    RD_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS     = 40;
  localparam int FIFO_CLK_PERIOD_NS = 160;
  localparam int FIFO_CLK_HALF_CYC  = (FIFO_CLK_PERIOD_NS / (2 * MCLK_PERIOD_NS)) < 1 ? 1 :
                                      (FIFO_CLK_PERIOD_NS / (2 * MCLK_PERIOD_NS));
  localparam int LINK_RST_HOLD_CYC  = 32;

  // one-hot decode of a FIFO number; numbers past the last FIFO select none
  function automatic logic [NUM_FIFOS-1:0] sel_onehot(input logic [SEL_W-1:0] sel);
    logic [NUM_FIFOS-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_FIFOS; i++) begin
      if (sel == i[SEL_W-1:0]) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // keep only the lowest set bit of a FIFO mask
  function automatic logic [NUM_FIFOS-1:0] lowest_bit(input logic [NUM_FIFOS-1:0] m);
    return m & (~m + 6'h01);
  endfunction

endpackage

// >>> hw/mfpa_sync.sv
`timescale 1ns/100ps
module mfpa_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             clk,
  // level in, level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------
  // two-flop chain; no reset so it can also carry a reset level
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end

endmodule

// >>> hw/mfpa_hshk.sv
`timescale 1ns/100ps
module mfpa_hshk #(
  parameter int WIDTH = 8
) (
  // source side
  input  wire logic             src_clk,
  input  wire logic             src_rst_n,
  input  wire logic [WIDTH-1:0] src_data,
  // destination side
  input  wire logic             dst_clk,
  input  wire logic             dst_rst_n,
  output logic      [WIDTH-1:0] dst_data
);

  logic             req;
  logic             ack;
  logic             req_s;
  logic             ack_s;
  logic [WIDTH-1:0] hold;

  // ----------------------------------------------------------------
  // source: resample whenever the previous word was taken
  // ----------------------------------------------------------------
  // hold stays still while a toggle is in flight, so dst may read it
  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      req  <= 1'b0;
      hold <= '0;
    end else if (ack_s == req) begin
      hold <= src_data;
      req  <= ~req;
    end
  end

  mfpa_sync #(.WIDTH(1)) u_ack_sync (
    .clk (src_clk),
    .d   (ack),
    .q   (ack_s)
  );

  mfpa_sync #(.WIDTH(1)) u_req_sync (
    .clk (dst_clk),
    .d   (req),
    .q   (req_s)
  );

  // ----------------------------------------------------------------
  // destination: take the word on each new toggle
  // ----------------------------------------------------------------
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      ack      <= 1'b0;
      dst_data <= '0;
    end else if (req_s != ack) begin
      dst_data <= hold;
      ack      <= req_s;
    end
  end

endmodule

// >>> bench/mfpa_fifo_model.sv
`timescale 1ns/100ps
module mfpa_fifo_model (
  // fifo clocks out and buffered copies back
  input  wire logic        ifc,
  input  wire logic        ofc,
  output logic             igc,
  output logic             ogc,
  // input fifos
  input  wire logic [5:0]  ren,
  input  wire logic [5:0]  oe,
  output logic      [31:0] rdata,
  output logic      [5:0]  empty,
  output logic      [5:0]  aempty,
  // output fifos
  input  wire logic [5:0]  wen,
  input  wire logic [31:0] wdata,
  output logic      [5:0]  full,
  output logic      [5:0]  afull
);
  int lvl [6];
  int room [6];
  int wcnt [6];
  logic [31:0] last [6];
  logic [31:0] q;
  // buffer delay, so the edges are not those of the source
  assign #7 igc = ifc;
  assign #7 ogc = ofc;
  initial begin
    q = 32'h0000_0000;
    for (int k = 0; k < 6; k++) begin
      lvl[k] = (k == 2) ? 7 : 0;
      room[k] = 6;
      wcnt[k] = 0;
      last[k] = 32'h0000_0000;
    end
  end
  // flags from fill levels; almost flags leave four words of slack
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      empty[k] = (lvl[k] == 0);
      aempty[k] = (lvl[k] < 5);
      full[k] = (room[k] == 0);
      afull[k] = (room[k] < 5);
    end
  end
  // released bus shows no stale word
  assign rdata = (|oe) ? q : ~q;
  always @(posedge igc) begin
    for (int k = 0; k < 6; k++) begin
      if (ren[k] && lvl[k] > 0) begin
        q <= 32'hA000_0000 + k * 256 + lvl[k];
        lvl[k] <= lvl[k] - 1;
      end
    end
  end
  always @(posedge ogc) begin
    for (int k = 0; k < 6; k++) begin
      if (wen[k] && room[k] > 0) begin
        room[k] <= room[k] - 1;
        wcnt[k] <= wcnt[k] + 1;
        last[k] <= wdata;
      end
    end
  end
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic mclk, reset_n, avs_read, avs_write, avs_waitrequest, ifc, ofc, igc, ogc, rx_valid, tx_valid, tx_ready;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata, wdata, rx_data, tx_data, rd;
  logic [5:0] ren, oe, empty, aempty, wen, full, afull;
  int errors = 0;
  int compares = 0;
  int nrx = 0;
  int cyc = 0;
  mfpa_top i_mfpa_top (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_fifo_clk(ifc), .out_fifo_clk(ofc), .in_global_clock_input(igc),
    .out_global_clock_input(ogc), .in_fifo_data(rdata), .in_fifo_empty(empty), .in_fifo_aempty(aempty),
    .in_fifo_ren(ren), .in_fifo_oe(oe), .out_fifo_data(wdata), .out_fifo_wen(wen), .out_fifo_full(full),
    .out_fifo_afull(afull), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  mfpa_fifo_model i_mfpa_fifo_model (.ifc(ifc), .ofc(ofc), .igc(igc), .ogc(ogc), .ren(ren), .oe(oe),
    .rdata(rdata), .empty(empty), .aempty(aempty), .wen(wen), .wdata(wdata), .full(full), .afull(afull));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // offer n words; the design paces them by tx_ready
  task automatic tx_words(input int n);
    int s;
    s = 0;
    @(posedge ogc);
    tx_data <= 32'h5000_0000;
    tx_valid <= 1'b1;
    repeat (60) begin
      @(posedge ogc);
      if (tx_valid && tx_ready === 1'b1) begin
        s++;
        tx_data <= 32'h5000_0000 + s;
        if (s == n) tx_valid <= 1'b0;
      end
    end
    if (s != n) tx_valid <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, receive checker
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  // words must come out in fifo order, no gaps or repeats
  always @(posedge igc) begin
    if (rx_valid === 1'b1) begin
      `CHK(rx_data, 32'hA000_0207 - nrx)
      nrx++;
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {reset_n, avs_read, avs_write, tx_valid} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    tx_data = 32'h0000_0000;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    bus(1'b0, mfpa_pkg::REG_OUT_CTRL, 32'h0);
    `CHK(rd, 32'h0000_0100)
    bus(1'b0, 5'h10, 32'h0);
    `CHK(rd, 32'h0000_0000)
    repeat (60) @(posedge mclk);
    bus(1'b1, mfpa_pkg::REG_IN_CTRL, 32'h0000_0021);
    bus(1'b1, mfpa_pkg::REG_OUT_CTRL, 32'h0000_0601);
    fork
      tx_words(10);
      repeat (240) @(posedge mclk);
    join
    `CHK(nrx, 7)
    `CHK(oe, 6'h04)
    `CHK(i_mfpa_fifo_model.wcnt[1], 6)
    `CHK(i_mfpa_fifo_model.wcnt[2], 0)
    `CHK(i_mfpa_fifo_model.last[1], 32'h5000_0005)
    bus(1'b0, mfpa_pkg::REG_IN_STAT, 32'h0);
    `CHK(rd & 32'h0003_FFFF, 32'h0003_0007)
    bus(1'b0, mfpa_pkg::REG_OUT_STAT, 32'h0);
    `CHK(rd & 32'h0003_FFFF, 32'h0003_0006)
    bus(1'b1, mfpa_pkg::REG_OUT_CTRL, 32'h0000_0C03);
    repeat (40) @(posedge mclk);
    tx_words(3);
    `CHK(i_mfpa_fifo_model.wcnt[2], 3)
    `CHK(i_mfpa_fifo_model.wcnt[3], 3)
    `CHK(i_mfpa_fifo_model.last[3], 32'h5000_0002)
    conclude();
  end
endmodule
